// ==== core/partial_network_wake_status.sv ====
// selective wake status registers: flags, frame error counter, bit time
`timescale 1ns/10ps
module partial_network_wake_status #(
  parameter int SILENCE_CYCLES = pn_wake_pkg::SILENCE_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic RESTART_IN,
  input wire logic [6:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  input wire logic FRAME_OK_IN,
  input wire logic FRAME_ERR_IN,
  input wire logic WAKE_PATTERN_IN,
  input wire logic WAKE_FRAME_IN,
  input wire logic BUS_ACTIVITY_IN,
  input wire logic CONFIG_VALID_IN,
  input wire logic WAKE_MODE_IN,
  input wire logic MODE_WR_IN,
  input wire logic [2:0] MODE_CODE_IN,
  input wire logic AVG_VALID_IN,
  input wire logic [pn_wake_pkg::AVG_WIDTH-1:0] AVG_CLOCKS_IN,
  output logic PARTIAL_WAKE_ACTIVE_OUT,
  output logic SYSTEM_ERROR_OUT,
  output logic CAN_WAKE_ENABLE_OUT
);
  import pn_wake_pkg::*;

  localparam int IDLE_W = $clog2(SILENCE_CYCLES + 1);
  localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(SILENCE_CYCLES);

  // ==========================================================
  // elaboration checks
  if (SILENCE_CYCLES < 1) begin : g_bad_silence
    $error("SILENCE_CYCLES must be at least one");
  end

  logic act_sync1;
  logic act_sync2;
  logic wake_enabled;
  logic system_error_flag;
  logic sync_flag;
  logic bus_silence_flag;
  logic wake_pattern_flag;
  logic wake_frame_flag;
  logic [COUNT_WIDTH-1:0] frame_error_count;
  logic [AVG_WIDTH-1:0] averaged_clocks_per_bit;
  logic [IDLE_W-1:0] idle_count;
  logic partial_wake_active;
  logic flags_read;
  logic overflow;
  logic [15:0] next_rdata;

  // ==========================================================
  // bus activity arrives from the pin, so it is synchronised first
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      act_sync1 <= 1'b0;
      act_sync2 <= 1'b0;
    end else begin
      act_sync1 <= BUS_ACTIVITY_IN;
      act_sync2 <= act_sync1;
    end
  end

  // ==========================================================
  // activation
  assign overflow = (frame_error_count == COUNT_OVERFLOW);
  assign partial_wake_active = wake_enabled && !system_error_flag
    && CONFIG_VALID_IN && WAKE_MODE_IN;
  // a read refused during restart must not clear flags it never returned
  assign flags_read = REG_RD_IN && !RESTART_IN && (REG_ADDR_IN == FLAGS_ADDR);

  // a mode write with any code but MODE_NO_START starts wake; overflow shuts it off and wins
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wake_enabled <= 1'b0;
    end else if (overflow) begin
      wake_enabled <= 1'b0;
    end else if (MODE_WR_IN && (MODE_CODE_IN != MODE_NO_START)) begin
      wake_enabled <= 1'b1;
    end
  end

  // system error and bus wake are sticky until a full reset
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      system_error_flag <= 1'b0;
      CAN_WAKE_ENABLE_OUT <= 1'b0;
    end else if (overflow) begin
      system_error_flag <= 1'b1;
      CAN_WAKE_ENABLE_OUT <= 1'b1;
    end
  end

  // ==========================================================
  // frame error counter; simultaneous error and good frame cancel
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      frame_error_count <= ERR_COUNT_RESET[COUNT_LSB +: COUNT_WIDTH];
    end else if (!overflow) begin
      if (FRAME_ERR_IN && !FRAME_OK_IN) begin
        frame_error_count <= frame_error_count + 6'h01;
      end else if (FRAME_OK_IN && !FRAME_ERR_IN && (frame_error_count != 6'h00)) begin
        frame_error_count <= frame_error_count - 6'h01;
      end
    end
  end

  // ==========================================================
  // synchronisation: lost as soon as the wake function stops
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sync_flag <= 1'b0;
    end else if (!partial_wake_active) begin
      sync_flag <= 1'b0;
    end else if (FRAME_OK_IN && !FRAME_ERR_IN) begin
      sync_flag <= 1'b1;
    end
  end

  // ==========================================================
  // silence timer saturates so the flag stays set while idle
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      idle_count <= '0;
      bus_silence_flag <= 1'b0;
    end else if (!partial_wake_active || act_sync2) begin
      idle_count <= '0;
      bus_silence_flag <= 1'b0;
    end else if (idle_count != IDLE_LIMIT) begin
      idle_count <= idle_count + IDLE_W'(1);
    end else begin
      bus_silence_flag <= 1'b1;
    end
  end

  // ==========================================================
  // read-to-clear wake flags
  sticky_flag u_pattern_flag (
    .CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN),
    .SET_IN(WAKE_PATTERN_IN),
    .CLEAR_IN(flags_read),
    .FLAG_OUT(wake_pattern_flag)
  );

  sticky_flag u_frame_flag (
    .CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN),
    .SET_IN(WAKE_FRAME_IN),
    .CLEAR_IN(flags_read),
    .FLAG_OUT(wake_frame_flag)
  );

  // ==========================================================
  // averaged bit time from the clock recovery filter
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      averaged_clocks_per_bit <= BIT_TIME_RESET[AVG_LSB +: AVG_WIDTH];
    end else if (AVG_VALID_IN) begin
      averaged_clocks_per_bit <= AVG_CLOCKS_IN;
    end
  end

  // ==========================================================
  // read mux; unmapped addresses return zero
  always_comb begin
    next_rdata = 16'h0000;
    unique case (REG_ADDR_IN)
      FLAGS_ADDR: begin
        next_rdata[SYNC_BIT] = sync_flag;
        next_rdata[PATTERN_BIT] = wake_pattern_flag;
        next_rdata[FRAME_BIT] = wake_frame_flag;
        next_rdata[SILENCE_BIT] = bus_silence_flag;
        next_rdata[ACTIVE_BIT] = partial_wake_active;
      end
      ERR_COUNT_ADDR: begin
        next_rdata[COUNT_LSB +: COUNT_WIDTH] = frame_error_count;
      end
      BIT_TIME_ADDR: begin
        next_rdata[AVG_LSB +: AVG_WIDTH] = averaged_clocks_per_bit;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // restart only wipes the read path; status state is untouched
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT <= 16'h0000;
      REG_RVALID_OUT <= 1'b0;
    end else if (RESTART_IN) begin
      REG_RDATA_OUT <= 16'h0000;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= next_rdata;
      end
    end
  end

  assign PARTIAL_WAKE_ACTIVE_OUT = partial_wake_active;
  assign SYSTEM_ERROR_OUT = system_error_flag;

  // ==========================================================
  // assertions
  property p_sync_cause;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      $rose(sync_flag) |-> $past(FRAME_OK_IN) && $past(partial_wake_active);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync without good frame");

  property p_sync_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (partial_wake_active && FRAME_OK_IN && !FRAME_ERR_IN) |=> sync_flag || !partial_wake_active;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("good frame did not sync");

  property p_pattern_clear;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (flags_read && !WAKE_PATTERN_IN) |=> !wake_pattern_flag && REG_RVALID_OUT
        && REG_RDATA_OUT[PATTERN_BIT] == $past(wake_pattern_flag);
  endproperty
  a_pattern_clear: assert property (p_pattern_clear) else $error("pattern flag not cleared");

  property p_frame_flag;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      WAKE_FRAME_IN ##1 (REG_RD_IN && REG_ADDR_IN == FLAGS_ADDR && !RESTART_IN)
        |=> REG_RDATA_OUT[FRAME_BIT];
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("frame flag not reported");

  property p_silence;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      bus_silence_flag |-> $past(partial_wake_active) && !$past(act_sync2);
  endproperty
  a_silence: assert property (p_silence) else $error("silence flag while bus busy");

  property p_no_start;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (!wake_enabled && MODE_WR_IN && MODE_CODE_IN == MODE_NO_START) |=> !wake_enabled;
  endproperty
  a_no_start: assert property (p_no_start) else $error("mode 100 started wake");

  property p_count_up;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (FRAME_ERR_IN && !FRAME_OK_IN && !overflow)
        |=> frame_error_count == $past(frame_error_count) + 6'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("error count did not rise");

  property p_count_down;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      (FRAME_OK_IN && !FRAME_ERR_IN && !overflow && frame_error_count != 6'h00)
        |=> frame_error_count == $past(frame_error_count) - 6'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("error count did not fall");

  property p_overflow;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      overflow |=> SYSTEM_ERROR_OUT && CAN_WAKE_ENABLE_OUT && !PARTIAL_WAKE_ACTIVE_OUT
        && frame_error_count == COUNT_OVERFLOW;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow actions missing");

  property p_reserved;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      REG_RVALID_OUT |-> REG_RDATA_OUT[3:0] == 4'h0 || $past(REG_ADDR_IN) != BIT_TIME_ADDR;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : partial_network_wake_status

// ==== core/pn_wake_pkg.sv ====
// constants shared by the selective wake status block
package pn_wake_pkg;
  // ==========================================================
  // register addresses (7-bit register address space)
  localparam logic [6:0] FLAGS_ADDR = 7'h60;
  localparam logic [6:0] ERR_COUNT_ADDR = 7'h61;
  localparam logic [6:0] BIT_TIME_ADDR = 7'h63;
  // ==========================================================
  // field positions
  localparam int SYNC_BIT = 6;
  localparam int PATTERN_BIT = 5;
  localparam int FRAME_BIT = 4;
  localparam int SILENCE_BIT = 3;
  localparam int ACTIVE_BIT = 2;
  localparam int COUNT_LSB = 0;
  localparam int COUNT_WIDTH = 6;
  localparam int AVG_LSB = 4;
  localparam int AVG_WIDTH = 12;
  // ==========================================================
  // reset values and codes
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] ERR_COUNT_RESET = 16'h0000;
  localparam logic [15:0] BIT_TIME_RESET = 16'hA000;
  localparam logic [5:0] COUNT_OVERFLOW = 6'h20;
  localparam logic [2:0] MODE_NO_START = 3'h4;
  // ==========================================================
  // timing
  localparam int CLOCK_HZ = 50000000;
  localparam int SILENCE_TIME_US = 1000;
  localparam int SILENCE_CYCLES_DEF = (SILENCE_TIME_US * (CLOCK_HZ / 1000000));
endpackage : pn_wake_pkg

// ==== core/sticky_flag.sv ====
// sticky status flag, hardware set wins over clear
`timescale 1ns/10ps
module sticky_flag (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SET_IN,
  input wire logic CLEAR_IN,
  output logic FLAG_OUT
);
  // ==========================================================
  // flag storage; a set in the clear cycle is kept, never lost
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      FLAG_OUT <= 1'b0;
    end else if (SET_IN) begin
      FLAG_OUT <= 1'b1;
    end else if (CLEAR_IN) begin
      FLAG_OUT <= 1'b0;
    end
  end

  property p_set_wins;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
      SET_IN |=> FLAG_OUT;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost a set event");
endmodule : sticky_flag

// ==== dv/can_bus_model.sv ====
// behavioural model of the bus side: other nodes sending frames and wake traffic
`timescale 1ns/10ps
module can_bus_model (
  input wire logic clk_in,
  output logic frame_ok_out,
  output logic frame_err_out,
  output logic wake_pattern_out,
  output logic wake_frame_out,
  output logic bus_activity_out
);
  // ==========================================================
  // event lines idle low; the bus starts busy so silence stays quiet
  initial begin
    frame_ok_out = 1'b0;
    frame_err_out = 1'b0;
    wake_pattern_out = 1'b0;
    wake_frame_out = 1'b0;
    bus_activity_out = 1'b1;
  end
  // one event line held for n edges, each edge is one received unit
  task automatic burst(input int kind, input int n);
    @(posedge clk_in);
    case (kind)
      0: frame_ok_out <= 1'b1;
      1: frame_err_out <= 1'b1;
      2: wake_pattern_out <= 1'b1;
      default: wake_frame_out <= 1'b1;
    endcase
    repeat (n) @(posedge clk_in);
    frame_ok_out <= 1'b0;
    frame_err_out <= 1'b0;
    wake_pattern_out <= 1'b0;
    wake_frame_out <= 1'b0;
  endtask : burst
  // bus level change, not tied to a frame boundary on purpose
  task automatic set_busy(input logic b);
    @(posedge clk_in);
    bus_activity_out <= b;
  endtask : set_busy
endmodule : can_bus_model

// ==== dv/test_partial_network_wake_status.sv ====
// self-checking bench for the selective wake status block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_partial_network_wake_status;
  import pn_wake_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, restart = 1'b0, rd = 1'b0, cfg = 1'b0, wmode = 1'b0;
  logic mwr = 1'b0, avg_v = 1'b0, rvalid, active, sys_error, wake_en;
  logic ok, err, pat, frm, busy;
  logic [6:0] addr = 7'h00;
  logic [2:0] code = 3'h0;
  logic [11:0] avg = 12'h000;
  logic [15:0] rdata;
  int failures = 0, check_count = 0;
  // ==========================================================
  // clock, device and bus model
  always #10 clk = ~clk;
  partial_network_wake_status #(.SILENCE_CYCLES(8)) uut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .RESTART_IN(restart), .REG_ADDR_IN(addr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .FRAME_OK_IN(ok), .FRAME_ERR_IN(err), .WAKE_PATTERN_IN(pat),
    .WAKE_FRAME_IN(frm), .BUS_ACTIVITY_IN(busy), .CONFIG_VALID_IN(cfg), .WAKE_MODE_IN(wmode),
    .MODE_WR_IN(mwr), .MODE_CODE_IN(code), .AVG_VALID_IN(avg_v), .AVG_CLOCKS_IN(avg),
    .PARTIAL_WAKE_ACTIVE_OUT(active), .SYSTEM_ERROR_OUT(sys_error), .CAN_WAKE_ENABLE_OUT(wake_en));
  can_bus_model bus (.clk_in(clk), .frame_ok_out(ok), .frame_err_out(err),
    .wake_pattern_out(pat), .wake_frame_out(frm), .bus_activity_out(busy));
  // ==========================================================
  // shared tasks
  task automatic print_verdict;
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // one read: strobe for one edge, answer lands one cycle later
  task automatic chk_reg(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK($sformatf("reg %h", a), e, rdata)
  endtask : chk_reg
  task automatic mode_wr(input logic [2:0] c);
    @(posedge clk);
    mwr <= 1'b1;
    code <= c;
    @(posedge clk);
    mwr <= 1'b0;
    #1;
  endtask : mode_wr
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk_reg(FLAGS_ADDR, FLAGS_RESET);
    chk_reg(ERR_COUNT_ADDR, ERR_COUNT_RESET);
    chk_reg(BIT_TIME_ADDR, BIT_TIME_RESET);
    chk_reg(7'h62, 16'h0000);
    `CHK("sys_error", 1'b0, sys_error)
    `CHK("wake_en", 1'b0, wake_en)
  endtask : t_reset
  task automatic t_activate;
    @(posedge clk);
    cfg <= 1'b1;
    wmode <= 1'b1;
    mode_wr(MODE_NO_START);
    `CHK("active", 1'b0, active)
    mode_wr(3'h1);
    `CHK("active", 1'b1, active)
    chk_reg(FLAGS_ADDR, 16'h0004);
    @(posedge clk);
    cfg <= 1'b0;
    #1;
    `CHK("active", 1'b0, active)
    @(posedge clk);
    cfg <= 1'b1;
  endtask : t_activate
  task automatic t_sync_flags;
    chk_reg(FLAGS_ADDR, 16'h0004);
    bus.burst(0, 1);
    chk_reg(FLAGS_ADDR, 16'h0044);
    bus.burst(2, 1);
    chk_reg(FLAGS_ADDR, 16'h0064);
    chk_reg(FLAGS_ADDR, 16'h0044);
    bus.burst(3, 1);
    chk_reg(FLAGS_ADDR, 16'h0054);
    chk_reg(FLAGS_ADDR, 16'h0044);
  endtask : t_sync_flags
  // idle past the shortened timeout, then traffic again
  task automatic t_silence;
    bus.set_busy(1'b0);
    repeat (16) @(posedge clk);
    chk_reg(FLAGS_ADDR, 16'h004C);
    bus.set_busy(1'b1);
    repeat (4) @(posedge clk);
    chk_reg(FLAGS_ADDR, 16'h0044);
  endtask : t_silence
  task automatic t_avg_restart;
    @(posedge clk);
    avg_v <= 1'b1;
    avg <= 12'h5A3;
    @(posedge clk);
    avg_v <= 1'b0;
    chk_reg(BIT_TIME_ADDR, 16'h5A30);
    // a flags read during restart is refused and must leave the pattern flag set
    bus.burst(2, 1);
    @(posedge clk);
    restart <= 1'b1;
    addr <= FLAGS_ADDR;
    rd <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    rd <= 1'b0;
    #1;
    `CHK("rdata", 16'h0000, rdata)
    `CHK("rvalid", 1'b0, rvalid)
    chk_reg(FLAGS_ADDR, 16'h0064);
    chk_reg(BIT_TIME_ADDR, 16'h5A30);
  endtask : t_avg_restart
  // count up, down, then run into overflow and past it
  task automatic t_errors;
    bus.burst(1, 2);
    chk_reg(ERR_COUNT_ADDR, 16'h0002);
    bus.burst(0, 1);
    chk_reg(ERR_COUNT_ADDR, 16'h0001);
    bus.burst(1, 40);
    chk_reg(ERR_COUNT_ADDR, 16'h0020);
    `CHK("sys_error", 1'b1, sys_error)
    `CHK("wake_en", 1'b1, wake_en)
    `CHK("active", 1'b0, active)
    chk_reg(FLAGS_ADDR, 16'h0000);
    bus.burst(0, 1);
    chk_reg(ERR_COUNT_ADDR, 16'h0020);
  endtask : t_errors
  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_activate();
    t_sync_flags();
    t_silence();
    t_avg_restart();
    t_errors();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : test_partial_network_wake_status
